// File: hdl/mwrc_pkg.sv
package mwrc_pkg;
  // Register map (word index on the plain register port)
  localparam logic [3:0] ADDR_MOD     = 4'h0;
  localparam logic [3:0] ADDR_RUN     = 4'h1;
  localparam logic [3:0] ADDR_DEPTH   = 4'h2;
  localparam logic [3:0] ADDR_MODFREQ = 4'h3;
  localparam logic [3:0] ADDR_DEV     = 4'h4;
  localparam logic [3:0] ADDR_START   = 4'h5;
  localparam logic [3:0] ADDR_STOP    = 4'h6;
  localparam logic [3:0] ADDR_SWTIME  = 4'h7;
  localparam logic [3:0] ADDR_MARKER  = 4'h8;
  localparam logic [3:0] ADDR_LOOPS   = 4'h9;
  localparam logic [3:0] ADDR_CMD     = 4'hA;
  localparam logic [3:0] ADDR_STATUS  = 4'hB;
  localparam logic [3:0] ADDR_CARRIER = 4'hC;
  // Mode register fields
  localparam int MOD_TYPE_LSB = 0;
  localparam int MOD_ENV_LSB  = 2;
  localparam int MOD_CSH_LSB  = 4;
  localparam int MOD_SWLOG    = 6;
  localparam int MOD_SWDOWN   = 7;
  localparam int MOD_ACCPL    = 8;
  // Run register fields
  localparam int RUN_MODE_LSB = 0;
  localparam int RUN_ARMED    = 2;
  localparam int RUN_ENEVT    = 3;
  localparam int RUN_INIT_LSB = 4;
  // Command register bits
  localparam int CMD_ENABLE   = 0;
  localparam int CMD_ABORT    = 1;
  localparam int CMD_INIT     = 2;
  // Limits and reset values
  localparam logic [6:0]  DEPTH_MAX    = 7'h64;
  localparam logic [26:0] MODFREQ_MIN  = 27'h000000A;  // Units of 1 mHz
  localparam logic [26:0] MODFREQ_MAX  = 27'h5F5E100;  // 100 kHz in mHz
  localparam logic [19:0] LOOPS_MIN    = 20'h00001;
  localparam logic [19:0] LOOPS_MAX    = 20'hF4240;
  localparam logic [26:0] MODFREQ_RST  = 27'h00003E8;
  localparam logic [31:0] SWTIME_RST   = 32'h00000064;
  localparam int          RELOAD_CYC   = 8;
  localparam int          SYNC_CYC     = 2;
  typedef enum logic [1:0] {MOD_OFF = 2'h0, MOD_AM = 2'h1, MOD_FM = 2'h2, MOD_SWEEP = 2'h3}
    mwrc_mod_e;
  typedef enum logic [1:0] {SHP_SINE = 2'h0, SHP_TRI = 2'h1, SHP_SQUARE = 2'h2, SHP_RAMP = 2'h3}
    mwrc_shape_e;
  typedef enum logic [1:0] {RUN_CONT = 2'h0, RUN_TRIG = 2'h1, RUN_GATED = 2'h2} mwrc_run_e;
  typedef enum logic [1:0] {INI_PANEL = 2'h0, INI_BUS = 2'h1, INI_TRIG = 2'h2} mwrc_init_e;
  typedef enum logic [2:0] {ST_RELOAD = 3'b000, ST_IDLE = 3'b001, ST_RUN = 3'b011,
                            ST_ABORT = 3'b010} mwrc_state_e;
endpackage

// File: hdl/mwrc_sweep.sv
`timescale 1ns/100ps
module mwrc_sweep
  import mwrc_pkg::*;
#(
  parameter int FW = 32
) (
  input  wire logic          clk_sys_i,
  input  wire logic          nrst_i,
  input  wire logic          restart_i,
  input  wire logic          step_i,
  input  wire logic          log_i,
  input  wire logic          down_i,
  input  wire logic [FW-1:0] start_i,
  input  wire logic [FW-1:0] stop_i,
  input  wire logic [31:0]   time_i,
  input  wire logic [FW-1:0] marker_i,
  output logic      [FW-1:0] freq_o,
  output logic               mark_o,
  output logic               done_o
);
  initial begin
    if (FW < 8) $error("mwrc_sweep: FW too small");
  end
  logic [31:0]   tick;
  logic [FW-1:0] from_f;
  logic [FW-1:0] to_f;
  logic [FW-1:0] span;
  logic [FW-1:0] lin_f;
  logic [FW-1:0] prev_f;
  logic [63:0]   prod;
  logic [31:0]   tdiv;
  logic [FW-1:0] lin_off;
  logic [63:0]   prod2;
  logic [FW-1:0] log_off;
  logic [FW-1:0] log_f;
  assign from_f = down_i ? stop_i : start_i;
  assign to_f   = down_i ? start_i : stop_i;
  assign tdiv   = (time_i == 32'h0) ? 32'h1 : time_i;
  assign span   = (to_f > from_f) ? to_f - from_f : from_f - to_f;
  assign prod   = 64'(span) * 64'(tick);
  // Linear steps spread over the full sweep time
  assign lin_off = FW'(prod / 64'(tdiv));
  assign lin_f  = (to_f > from_f) ? from_f + lin_off : from_f - lin_off;
  // Convex steps approximate a logarithmic sweep and still end on time
  assign prod2   = 64'(lin_off) * 64'(tick);
  assign log_off = FW'(prod2 / 64'(tdiv));
  assign log_f   = (to_f > from_f) ? from_f + log_off : from_f - log_off;
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i || restart_i) begin
      tick   <= 32'h0;
      freq_o <= '0;
      done_o <= 1'b0;
    end else if (step_i && !done_o) begin
      if (tick >= tdiv) begin
        freq_o <= to_f;
        done_o <= 1'b1;
      end else if (log_i) begin
        freq_o <= log_f;
        tick   <= tick + 32'h1;
      end else begin
        freq_o <= lin_f;
        tick   <= tick + 32'h1;
      end
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i || restart_i) begin
      prev_f <= '0;
      mark_o <= 1'b0;
    end else begin
      prev_f <= freq_o;
      mark_o <= (tick > 32'h1) && ((prev_f < marker_i && freq_o >= marker_i) ||
                (prev_f > marker_i && freq_o <= marker_i));
    end
  end
endmodule

// File: hdl/mwrc_fm_marker.sv
`timescale 1ns/100ps
module mwrc_fm_marker
  import mwrc_pkg::*;
#(
  parameter int FW = 32
) (
  input  wire logic          clk_sys_i,
  input  wire logic          nrst_i,
  input  wire logic          run_i,
  input  wire logic          tick_i,
  input  wire logic [FW-1:0] carrier_i,
  input  wire logic [FW-1:0] dev_i,
  input  wire logic [FW-1:0] marker_i,
  output logic      [FW-1:0] freq_o,
  output logic               mark_o
);
  initial begin
    if (FW < 8) $error("mwrc_fm_marker: FW too small");
  end
  logic          rising;
  logic [FW-1:0] half;
  logic [FW-1:0] step;
  logic [FW-1:0] prev_f;
  assign half = dev_i >> 1;
  assign step = (half >> 4) + FW'(1);
  // Triangle excursion, symmetric around the carrier
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i || !run_i) begin
      freq_o <= carrier_i;
      rising <= 1'b1;
    end else if (tick_i) begin
      if (rising && freq_o + step >= carrier_i + half) begin
        freq_o <= carrier_i + half;
        rising <= 1'b0;
      end else if (!rising && freq_o <= carrier_i - half + step) begin
        freq_o <= carrier_i - half;
        rising <= 1'b1;
      end else begin
        freq_o <= rising ? freq_o + step : freq_o - step;
      end
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i || !run_i) begin
      prev_f <= carrier_i;
      mark_o <= 1'b0;
    end else begin
      prev_f <= freq_o;
      mark_o <= (prev_f != freq_o) && (freq_o == marker_i ||
                (prev_f < marker_i && freq_o > marker_i) ||
                (prev_f > marker_i && freq_o < marker_i));
    end
  end
endmodule

// File: hdl/mwrc_top.sv
`timescale 1ns/100ps
// Contract
// - Modulation off/AM/FM/sweep applied at once
// - AM envelope sine, triangle, square or ramp
// - AM depth percent, 0 to 100
// - Modulating frequency 10 mHz to 100 kHz
// - One shared carrier shape: sine/triangle/square
// - Standard FM always uses sine carrier
// - FM deviation symmetric around carrier
// - FM sync pulse at marker frequency
// - Sweep steps linear or logarithmic
// - Up start-to-stop, down stop-to-start
// - One sweep lasts exactly sweep time
// - Sweep marker pulse on sync crossing
// - AC coupling: power level, no offset
// - Continuous, triggered once, or gated run
// - Self-armed free; armed waits for enable, initiate or gate per run mode
// - Armed idle holds first waveform point
// - Enable by command or event, continuous
// - Abort stops armed output, ignored self-armed
// - Initiate sources per triggered/gated mode
// - Remote initiate disables front panel
// - Triggered armed repeats 1 to 1M loops; in sweep mode one sweep runs, then the remaining loops count off one per cycle
// - Smart trigger only armed triggered
// - Parameter change stops, reloads, resumes
module mwrc_top
  import mwrc_pkg::*;
#(
  parameter int FW          = 32,
  parameter int CYC_PER_PER = 20
) (
  input  wire logic          clk_sys_i,
  input  wire logic          nrst_i,
  input  wire logic [3:0]    addr_i,
  input  wire logic [31:0]   wdata_i,
  input  wire logic          wr_i,
  input  wire logic          rd_i,
  output logic      [31:0]   rdata_o,
  input  wire logic          panel_btn_i,
  input  wire logic          trig_in_i,
  input  wire logic          event_in_i,
  output logic               out_run_o,
  output logic               out_idle_o,
  output logic [1:0]         mod_type_o,
  output logic [1:0]         env_shape_o,
  output logic [1:0]         carrier_tone_shape_o,
  output logic               power_mode_o,
  output logic               offset_en_o,
  output logic               smart_trig_o,
  output logic [FW-1:0]      freq_o,
  output logic               sync_o
);
  initial begin
    if (FW < 8 || FW > 32) $error("mwrc_top: FW must be 8 to 32");
    if (CYC_PER_PER < 1) $error("mwrc_top: CYC_PER_PER must be positive");
  end
  logic [8:0]    mod_reg;
  logic [6:0]    run_reg;
  logic [6:0]    depth;
  logic [26:0]   modfreq;
  logic [FW-1:0] dev;
  logic [FW-1:0] f_start;
  logic [FW-1:0] f_stop;
  logic [31:0]   sw_time;
  logic [FW-1:0] marker;
  logic [19:0]   loops;
  logic [FW-1:0] carrier_f;
  logic          cfg_chg;
  mwrc_state_e   state;
  logic [3:0]    rl_cnt;
  logic [19:0]   loop_cnt;
  logic          enabled;
  logic          trig_q;
  logic          evt_q;
  logic          btn_q;
  logic [15:0]   div_cnt;
  logic          tick;
  logic [1:0]    sync_cnt;
  logic          sw_restart;
  logic [FW-1:0] sw_freq;
  logic          sw_mark;
  logic          sw_done;
  logic [FW-1:0] fm_freq;
  logic          fm_mark;
  mwrc_run_e     run_mode;
  mwrc_init_e    init_src;
  mwrc_mod_e     mtype;
  logic          armed;
  logic          trig_edge;
  logic          evt_edge;
  logic          btn_edge;
  logic          cmd_wr;
  logic          init_ok;
  logic          gate_on;
  logic          end_wave;
  assign run_mode  = mwrc_run_e'(run_reg[RUN_MODE_LSB +: 2]);
  assign init_src  = mwrc_init_e'(run_reg[RUN_INIT_LSB +: 2]);
  assign mtype     = mwrc_mod_e'(mod_reg[MOD_TYPE_LSB +: 2]);
  assign armed     = run_reg[RUN_ARMED];
  assign trig_edge = trig_in_i && !trig_q;
  assign evt_edge  = event_in_i && !evt_q;
  assign btn_edge  = panel_btn_i && !btn_q;
  assign cmd_wr    = wr_i && addr_i == ADDR_CMD;
  // Initiate source gating per run mode
  always_comb begin
    init_ok = 1'b0;
    case (init_src)
      INI_PANEL: init_ok = btn_edge;
      INI_BUS:   init_ok = run_mode == RUN_TRIG && cmd_wr && wdata_i[CMD_INIT];
      INI_TRIG:  init_ok = trig_edge;
      default:   init_ok = 1'b0;
    endcase
  end
  assign gate_on  = (init_src == INI_TRIG) ? trig_in_i :
                    (init_src == INI_PANEL) ? panel_btn_i : 1'b0;
  assign tick     = state == ST_RUN && div_cnt == 16'(CYC_PER_PER - 1);
  assign end_wave = (mtype == MOD_SWEEP) ? sw_done : tick;
  // Register writes with range clamping
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      mod_reg   <= '0;
      run_reg   <= '0;
      depth     <= '0;
      modfreq   <= MODFREQ_RST;
      dev       <= '0;
      f_start   <= '0;
      f_stop    <= '0;
      sw_time   <= SWTIME_RST;
      marker    <= '0;
      loops     <= LOOPS_MIN;
      carrier_f <= '0;
      cfg_chg   <= 1'b0;
    end else begin
      cfg_chg <= wr_i && addr_i != ADDR_CMD && addr_i <= ADDR_CARRIER;
      if (wr_i) begin
        case (addr_i)
          ADDR_MOD:     mod_reg   <= wdata_i[8:0];
          ADDR_RUN:     run_reg   <= wdata_i[6:0];
          ADDR_DEPTH:   depth     <= (wdata_i[6:0] > DEPTH_MAX || wdata_i[31:7] != '0)
                                     ? DEPTH_MAX : wdata_i[6:0];
          ADDR_MODFREQ: modfreq   <= (wdata_i[26:0] > MODFREQ_MAX || wdata_i[31:27] != '0)
                                     ? MODFREQ_MAX : (wdata_i[26:0] < MODFREQ_MIN)
                                     ? MODFREQ_MIN : wdata_i[26:0];
          ADDR_DEV:     dev       <= wdata_i[FW-1:0];
          ADDR_START:   f_start   <= wdata_i[FW-1:0];
          ADDR_STOP:    f_stop    <= wdata_i[FW-1:0];
          ADDR_SWTIME:  sw_time   <= wdata_i;
          ADDR_MARKER:  marker    <= wdata_i[FW-1:0];
          ADDR_LOOPS:   loops     <= (wdata_i[19:0] > LOOPS_MAX || wdata_i[31:20] != '0)
                                     ? LOOPS_MAX : (wdata_i[19:0] < LOOPS_MIN)
                                     ? LOOPS_MIN : wdata_i[19:0];
          ADDR_CARRIER: carrier_f <= wdata_i[FW-1:0];
          default:      ;
        endcase
      end
    end
  end
  // Register read, data valid the cycle after the strobe
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      case (addr_i)
        ADDR_MOD:     rdata_o <= {23'h0, mod_reg};
        ADDR_RUN:     rdata_o <= {25'h0, run_reg};
        ADDR_DEPTH:   rdata_o <= {25'h0, depth};
        ADDR_MODFREQ: rdata_o <= {5'h0, modfreq};
        ADDR_DEV:     rdata_o <= 32'(dev);
        ADDR_START:   rdata_o <= 32'(f_start);
        ADDR_STOP:    rdata_o <= 32'(f_stop);
        ADDR_SWTIME:  rdata_o <= sw_time;
        ADDR_MARKER:  rdata_o <= 32'(marker);
        ADDR_LOOPS:   rdata_o <= {12'h0, loops};
        ADDR_STATUS:  rdata_o <= {6'h0, loop_cnt, enabled, out_idle_o, out_run_o, state};
        ADDR_CARRIER: rdata_o <= 32'(carrier_f);
        default:      rdata_o <= '0;
      endcase
    end else begin
      rdata_o <= '0;
    end
  end
  // Input edge capture and modulation-period divider
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      trig_q  <= 1'b0;
      evt_q   <= 1'b0;
      btn_q   <= 1'b0;
      div_cnt <= '0;
    end else begin
      trig_q  <= trig_in_i;
      evt_q   <= event_in_i;
      btn_q   <= panel_btn_i;
      div_cnt <= (div_cnt == 16'(CYC_PER_PER - 1) || state != ST_RUN) ? '0 : div_cnt + 16'h1;
    end
  end
  // Run control state machine
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      state    <= ST_RELOAD;
      rl_cnt   <= '0;
      loop_cnt <= '0;
      enabled  <= 1'b0;
    end else if (cfg_chg) begin
      state  <= ST_RELOAD;
      rl_cnt <= '0;
    end else if (armed && cmd_wr && wdata_i[CMD_ABORT]) begin
      state   <= ST_ABORT;
      enabled <= 1'b0;
    end else begin
      if (run_mode == RUN_CONT && armed &&
          ((run_reg[RUN_ENEVT] && evt_edge) ||
           (!run_reg[RUN_ENEVT] && cmd_wr && wdata_i[CMD_ENABLE]))) begin
        enabled <= 1'b1;
      end
      case (state)
        ST_RELOAD: begin
          rl_cnt <= rl_cnt + 4'h1;
          if (rl_cnt == 4'(RELOAD_CYC - 1)) begin
            state <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (!armed && run_mode == RUN_CONT) begin
            state <= ST_RUN;
          end else if (run_mode == RUN_CONT && (enabled || !armed)) begin
            state <= ST_RUN;
          end else if (armed && run_mode == RUN_TRIG && init_ok) begin
            state    <= ST_RUN;
            loop_cnt <= loops;
          end else if (armed && run_mode == RUN_GATED && gate_on) begin
            state <= ST_RUN;
          end else if (!armed) begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (armed && run_mode == RUN_GATED && !gate_on) begin
            state <= ST_IDLE;
          end else if (armed && run_mode == RUN_TRIG && end_wave) begin
            if (loop_cnt <= 20'h1) begin
              state    <= ST_IDLE;
              loop_cnt <= '0;
            end else begin
              loop_cnt <= loop_cnt - 20'h1;
            end
          end else if (armed && run_mode == RUN_CONT && !enabled) begin
            state <= ST_IDLE;
          end
        end
        ST_ABORT: begin
          if (!armed) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_RELOAD;
      endcase
    end
  end
  assign sw_restart = state != ST_RUN || (mtype == MOD_SWEEP && sw_done && !armed) ||
                      (mtype == MOD_SWEEP && sw_done && run_mode != RUN_TRIG);
  mwrc_sweep #(.FW(FW)) u_sweep (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .restart_i (sw_restart),
    .step_i    (state == ST_RUN && mtype == MOD_SWEEP),
    .log_i     (mod_reg[MOD_SWLOG]),
    .down_i    (mod_reg[MOD_SWDOWN]),
    .start_i   (f_start),
    .stop_i    (f_stop),
    .time_i    (sw_time),
    .marker_i  (marker),
    .freq_o    (sw_freq),
    .mark_o    (sw_mark),
    .done_o    (sw_done)
  );
  mwrc_fm_marker #(.FW(FW)) u_fm (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .run_i     (state == ST_RUN && mtype == MOD_FM),
    .tick_i    (1'b1),
    .carrier_i (carrier_f),
    .dev_i     (dev),
    .marker_i  (marker),
    .freq_o    (fm_freq),
    .mark_o    (fm_mark)
  );
  // Output stage, all from flip-flops
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      out_run_o            <= 1'b0;
      out_idle_o           <= 1'b1;
      mod_type_o           <= 2'h0;
      env_shape_o          <= 2'h0;
      carrier_tone_shape_o <= 2'h0;
      power_mode_o         <= 1'b0;
      offset_en_o          <= 1'b1;
      smart_trig_o         <= 1'b0;
      freq_o               <= '0;
    end else begin
      out_run_o    <= state == ST_RUN;
      out_idle_o   <= state != ST_RUN;
      mod_type_o   <= mtype;
      env_shape_o  <= mod_reg[MOD_ENV_LSB +: 2];
      carrier_tone_shape_o <= (mtype == MOD_FM) ? 2'(SHP_SINE) :
                              (mod_reg[MOD_CSH_LSB +: 2] == 2'(SHP_RAMP)) ? 2'(SHP_SINE)
                              : mod_reg[MOD_CSH_LSB +: 2];
      power_mode_o <= mod_reg[MOD_ACCPL];
      offset_en_o  <= !mod_reg[MOD_ACCPL];
      smart_trig_o <= armed && run_mode == RUN_TRIG;
      freq_o       <= (state != ST_RUN) ? ((mtype == MOD_SWEEP) ?
                      (mod_reg[MOD_SWDOWN] ? f_stop : f_start) : carrier_f) :
                      (mtype == MOD_SWEEP) ? sw_freq :
                      (mtype == MOD_FM) ? fm_freq : carrier_f;
    end
  end
  // Sync marker pulse stretch
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      sync_cnt <= '0;
      sync_o   <= 1'b0;
    end else begin
      if ((mtype == MOD_SWEEP && sw_mark) || (mtype == MOD_FM && fm_mark)) begin
        sync_cnt <= 2'(SYNC_CYC - 1);
        sync_o   <= 1'b1;
      end else if (sync_cnt != 2'h0) begin
        sync_cnt <= sync_cnt - 2'h1;
      end else begin
        sync_o <= 1'b0;
      end
    end
  end
endmodule

// File: verification/mwrc_monitor.sv
`timescale 1ns/100ps
module mwrc_monitor
  import mwrc_pkg::*;
#(
  parameter int FW = 32
) (
  input wire logic       clk_sys_i,
  input wire logic       nrst_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       out_run_o,
  input wire logic       out_idle_o,
  input wire logic [1:0] mod_type_o,
  input wire logic [1:0] carrier_tone_shape_o,
  input wire logic       power_mode_o,
  input wire logic       offset_en_o,
  input wire logic       smart_trig_o,
  input wire logic       sync_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);
  // Writes that force a stop and reload
  sequence s_cfg_wr;
    wr_i && addr_i <= ADDR_CARRIER && addr_i != ADDR_CMD && addr_i != ADDR_STATUS;
  endsequence
  sequence s_mod_wr;
    wr_i && addr_i == ADDR_MOD;
  endsequence
  sequence s_stopped;
    !out_run_o [*8];
  endsequence
  a_reload_stops: assert property (s_cfg_wr |-> ##3 s_stopped)
    else $error("output ran during reload");
  a_mod_applied: assert property (s_mod_wr |-> ##2 mod_type_o == $past(wdata_i[1:0], 2))
    else $error("modulation type not applied");
  a_ac_power: assert property (s_mod_wr |-> ##2 power_mode_o == $past(wdata_i[MOD_ACCPL], 2))
    else $error("power level mode not applied");
  a_offset_excl: assert property (offset_en_o != power_mode_o)
    else $error("offset offered with AC coupling");
  a_fm_sine: assert property (mod_type_o == MOD_FM && $past(mod_type_o) == MOD_FM
    |-> carrier_tone_shape_o == SHP_SINE)
    else $error("FM carrier not sine");
  a_smart_armed: assert property (wr_i && addr_i == ADDR_RUN
    |-> ##2 smart_trig_o == $past(wdata_i[RUN_ARMED] && wdata_i[1:0] == RUN_TRIG, 2))
    else $error("smart trigger flag wrong");
  a_run_idle: assert property (!(out_run_o && out_idle_o))
    else $error("idle level while generating");
  a_sync_pulse: assert property ($rose(sync_o) |=> sync_o ##1 !sync_o)
    else $error("sync pulse not two cycles");
endmodule

// File: verification/mwrc_host_model.sv
`timescale 1ns/100ps
module mwrc_host_model (
  input  wire logic clk_sys_i,
  output logic      panel_btn_o,
  output logic      trig_o,
  output logic      event_o
);
  logic [2:0] lines = 3'h0;
  int         cnt [3] = '{0, 0, 0};
  // Each line stands for the commanded cycles, then falls
  always @(posedge clk_sys_i) begin
    for (int i = 0; i < 3; i++) begin
      lines[i] <= cnt[i] > 0;
      cnt[i]   <= (cnt[i] > 0) ? cnt[i] - 1 : 0;
    end
  end
  assign panel_btn_o = lines[0];
  assign trig_o      = lines[1];
  assign event_o     = lines[2];
  task automatic press(input int sel, input int len);
    cnt[sel] = len;
  endtask
endmodule

// File: verification/tb.sv
`timescale 1ns/100ps
module tb;
  import mwrc_pkg::*;
  localparam int CYC = 4;
  localparam logic [31:0] TV [9][3] = '{'{2, 32'h64, 32'h64}, '{2, 32'h65, 32'h64},
    '{3, 32'h9, 32'hA}, '{3, 32'h5F5E100, 32'h5F5E100}, '{3, 32'h5F5E101, 32'h5F5E100},
    '{9, 0, 1}, '{9, 32'hF4240, 32'hF4240}, '{9, 32'hF4241, 32'hF4240}, '{14, 5, 0}};
  logic        clk_sys_i, nrst_i, wr_i, rd_i, panel_btn_i, trig_in_i, event_in_i;
  logic [3:0]  addr_i;
  logic [31:0] wdata_i, rdata_o, freq_o;
  logic        out_run_o, out_idle_o, power_mode_o, offset_en_o, smart_trig_o, sync_o;
  logic [1:0]  mod_type_o, env_shape_o, carrier_tone_shape_o;
  int          bad_count = 0;
  int          checks = 0;
  mwrc_top #(.FW(32), .CYC_PER_PER(CYC)) uut (.clk_sys_i, .nrst_i, .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .panel_btn_i, .trig_in_i, .event_in_i, .out_run_o,
    .out_idle_o, .mod_type_o, .env_shape_o, .carrier_tone_shape_o, .power_mode_o,
    .offset_en_o, .smart_trig_o, .freq_o, .sync_o);
  mwrc_host_model host (.clk_sys_i, .panel_btn_o(panel_btn_i), .trig_o(trig_in_i),
    .event_o(event_in_i));
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  task automatic report_and_stop();
    if (bad_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task automatic cfg(input logic [3:0] a, input logic [31:0] d);
    wr(a, d);
    step(12);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask
  task automatic wait_run(input logic lvl, input int lim);
    step(1);
    for (int i = 0; i < lim && out_run_o !== lvl; i++) step(1);
    chk("run", 32'(lvl), 32'(out_run_o));
  endtask
  task automatic run_len(output int n);
    for (n = 0; n < 1000 && out_run_o === 1'b1; n++) step(1);
  endtask
  task automatic t_reset();
    step(1);
    chk("idle", 1, out_idle_o);
    chk("offs", 1, offset_en_o);
    wait_run(1, 16);
  endtask
  task automatic t_mod();
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_MOD, 32'(i) | 32'(i << MOD_ENV_LSB) | 32'h10 | 32'((i % 2) << MOD_ACCPL));
      step(2);
      chk("mod", i, mod_type_o);
      chk("env", i, env_shape_o);
      chk("shape", (i == 2) ? 0 : 1, carrier_tone_shape_o);
      chk("pwr", i % 2, power_mode_o);
      wait_run(1, 14);
    end
  endtask
  task automatic t_regs();
    logic [31:0] d;
    for (int i = 0; i < 9; i++) begin
      wr(TV[i][0][3:0], TV[i][1]);
      rd(TV[i][0][3:0], d);
      chk("reg", TV[i][2], d);
    end
  endtask
  task automatic t_armed();
    wr(ADDR_MOD, 0);
    wr(ADDR_CARRIER, 32'h3E8);
    cfg(ADDR_RUN, 32'h4);
    chk("idle", 1, out_idle_o);
    chk("freq", 32'h3E8, freq_o);
    chk("smart", 0, smart_trig_o);
    wr(ADDR_CMD, 32'h1);
    wait_run(1, 6);
    wr(ADDR_CMD, 32'h2);
    wait_run(0, 6);
    cfg(ADDR_RUN, 0);
    wr(ADDR_CMD, 32'h2);
    step(6);
    chk("run", 1, out_run_o);
    cfg(ADDR_RUN, 32'hC);
    chk("run", 0, out_run_o);
    host.press(2, 2);
    wait_run(1, 6);
  endtask
  task automatic t_trig();
    int n;
    wr(ADDR_MOD, 32'h1);
    wr(ADDR_LOOPS, 32'h3);
    cfg(ADDR_RUN, 32'h25);
    chk("smart", 1, smart_trig_o);
    host.press(1, 2);
    wait_run(1, 8);
    run_len(n);
    chk("loops", 3 * CYC, n);
    step(1);
    chk("idle", 1, out_idle_o);
    cfg(ADDR_RUN, 32'h5);
    host.press(0, 2);
    wait_run(1, 8);
    run_len(n);
    cfg(ADDR_RUN, 32'h15);
    host.press(0, 2);
    step(5);
    chk("run", 0, out_run_o);
    wr(ADDR_CMD, 32'h4);
    wait_run(1, 8);
    run_len(n);
    chk("loops", 3 * CYC, n);
  endtask
  task automatic t_gate();
    cfg(ADDR_RUN, 32'h26);
    host.press(1, 12);
    wait_run(1, 6);
    step(8);
    chk("run", 1, out_run_o);
    wait_run(0, 8);
  endtask
  task automatic t_fm();
    logic [31:0] lo;
    logic [31:0] hi;
    logic        sy;
    lo = '1;
    hi = '0;
    sy = 1'b0;
    wr(ADDR_RUN, 0);
    wr(ADDR_DEV, 32'hC8);
    wr(ADDR_MARKER, 32'h3E8);
    cfg(ADDR_MOD, 32'h2);
    for (int i = 0; i < 80; i++) begin
      step(1);
      lo = (freq_o < lo) ? freq_o : lo;
      hi = (freq_o > hi) ? freq_o : hi;
      sy = sy | sync_o;
    end
    chk("fsum", 32'h7D0, lo + hi);
    chk("fhi", 1, hi > 32'h3E8);
    chk("fsync", 1, sy);
  endtask
  task automatic t_sweep();
    int          n;
    logic [31:0] f0;
    logic [31:0] f1;
    logic        sy;
    logic [31:0] mid [3];
    wr(ADDR_START, 32'h64);
    wr(ADDR_STOP, 32'h1F4);
    wr(ADDR_SWTIME, 32'h28);
    wr(ADDR_MARKER, 32'h12C);
    for (int j = 0; j < 3; j++) begin
      f0 = (j == 1) ? 32'h1F4 : 32'h64;
      f1 = (j == 1) ? 32'h64 : 32'h1F4;
      cfg(ADDR_MOD, 32'h3 | (32'(j == 2) << MOD_SWLOG) | (32'(j == 1) << MOD_SWDOWN));
      for (n = 0; n < 200 && freq_o !== f1; n++) step(1);
      for (n = 0; n < 200 && freq_o !== f0; n++) step(1);
      sy = 1'b0;
      for (n = 0; n < 200 && freq_o !== f1; n++) begin
        step(1);
        sy = sy | sync_o;
        if (n == 19) mid[j] = freq_o;
      end
      chk("stime", 40, n);
      chk("smark", 1, sy);
    end
    chk("slog", 1, mid[2] < mid[0]);
  endtask
  initial begin
    nrst_i  = 1'b0;
    addr_i  = 4'h0;
    wdata_i = 32'h0;
    wr_i    = 1'b0;
    rd_i    = 1'b0;
    repeat (2) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    t_reset();
    t_mod();
    t_regs();
    t_armed();
    t_trig();
    t_gate();
    t_fm();
    t_sweep();
    report_and_stop();
  end
  initial begin
    #1000000;
    bad_count++;
    report_and_stop();
  end
endmodule
bind mwrc_top mwrc_monitor #(.FW(FW)) u_mon (.clk_sys_i, .nrst_i, .addr_i, .wdata_i, .wr_i,
  .out_run_o, .out_idle_o, .mod_type_o, .carrier_tone_shape_o, .power_mode_o, .offset_en_o,
  .smart_trig_o, .sync_o);
